// ===== sfcf_top.sv
// Serial flash command framing front end with mode 0/3 serial link
// Notes on behaviour
// - Unknown command: standby until select rises
// - Standby keeps serial output undriven
// - Valid command: active until select rises, except an array command while busy, which goes to standby
// - Inputs sampled on rising serial clock
// - Output changes on falling serial clock
// - Serial modes 0 and 3 only
// - Read-class commands get data-out phase
// - Read may end after any bit
// - Off-boundary end rejects modifying command
// - Array access ignored while busy
module sfcf_top
    import sfcf_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        si_i,
    input  wire logic        busy_i,
    input  wire logic [7:0]  resp_data_i,
    output logic             so_o,
    output logic             so_oe_n_o,
    output logic             active_o,
    output logic [7:0]       cmd_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic             exec_o,
    output logic             reject_o,
    output logic             load_o
);
    // Properties below run on the system clock, off during reset
    default clocking sfcf_sys_cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);

    // Refuse a command width the shifter cannot serve
    if (CMD_W != 8) begin : g_cmd_width_check
        $error("Command width must be 8");
    end

    typedef enum logic [1:0] {
        SFCF_IDLE,
        SFCF_CMD,
        SFCF_ACTIVE,
        SFCF_STANDBY
    } sfcf_state_e;

    // Classify a received command byte
    function automatic sfcf_cls_e sfcf_classify(input logic [7:0] c);
        unique case (c)
            read_identification_cmd, read_status_cmd,
            read_block_lock_status_cmd, CMD_READ_C, CMD_FREAD_C,
            dual_output_array_read_cmd, quad_output_array_read_cmd,
            dual_io_array_read_cmd, quad_io_array_read_cmd:
                return SFCF_CLS_READ;
            write_enable_cmd, write_disable_cmd, block_write_lock_cmd,
            CMD_UNPROT_C, quad_page_program_cmd, sector_erase_cmd,
            page_program_cmd:
                return SFCF_CLS_MOD;
            default:
                return SFCF_CLS_BAD;
        endcase
    endfunction

    // True for commands that touch the memory array
    function automatic logic sfcf_is_array(input logic [7:0] c);
        return (c == CMD_READ_C) || (c == CMD_FREAD_C) ||
               (c == dual_output_array_read_cmd) ||
               (c == quad_output_array_read_cmd) ||
               (c == dual_io_array_read_cmd) ||
               (c == quad_io_array_read_cmd) ||
               (c == quad_page_program_cmd) || (c == sector_erase_cmd) ||
               (c == page_program_cmd) || (c == block_write_lock_cmd);
    endfunction

    logic [1:0] sclk_sync_reg;
    logic [1:0] cs_sync_reg;
    logic [1:0] si_sync_reg;
    logic       sclk_d_reg;
    logic       cs_d_reg;
    // Two-flop synchronisers for the pins
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sclk_sync_reg <= 2'h0;
            cs_sync_reg   <= 2'h3;
            si_sync_reg   <= 2'h0;
            sclk_d_reg    <= 1'b0;
            cs_d_reg      <= 1'b1;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[0], sclk_i};
            cs_sync_reg   <= {cs_sync_reg[0], cs_n_i};
            si_sync_reg   <= {si_sync_reg[0], si_i};
            sclk_d_reg    <= sclk_sync_reg[1];
            cs_d_reg      <= cs_sync_reg[1];
        end
    end

    logic sclk_s;
    logic cs_s;
    logic si_s;
    logic rise;
    logic fall;
    logic cs_fall;
    logic cs_rise;
    // Edge detection on synchronised levels
    assign sclk_s  = sclk_sync_reg[1];
    assign cs_s    = cs_sync_reg[1];
    assign si_s    = si_sync_reg[1];
    assign rise    = sclk_s & ~sclk_d_reg & ~cs_s;
    assign fall    = ~sclk_s & sclk_d_reg & ~cs_s;
    assign cs_fall = ~cs_s & cs_d_reg;
    assign cs_rise = cs_s & ~cs_d_reg;

    sfcf_state_e state_reg;
    logic [2:0]  bit_cnt_reg;
    logic [7:0]  shift_reg;
    logic [1:0]  byte_cnt_reg;
    sfcf_cls_e   cls_reg;
    logic [7:0]  shift_next;
    assign shift_next = {shift_reg[6:0], si_s};

    // Bit and byte counting within a frame
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bit_cnt_reg  <= 3'h0;
            shift_reg    <= 8'h00;
            byte_cnt_reg <= 2'h0;
        end else if (cs_fall) begin
            bit_cnt_reg  <= 3'h0;
            byte_cnt_reg <= 2'h0;
        end else if (rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg   <= shift_next;
            if (bit_cnt_reg == 3'h7 && state_reg == SFCF_ACTIVE &&
                byte_cnt_reg != 2'h3) begin
                byte_cnt_reg <= byte_cnt_reg + 2'h1;
            end
        end
    end

    // Frame state: command, active or standby
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= SFCF_IDLE;
            cls_reg   <= SFCF_CLS_BAD;
            cmd_o     <= 8'h00;
        end else if (cs_fall) begin
            state_reg <= SFCF_CMD;
        end else if (cs_rise) begin
            state_reg <= SFCF_IDLE;
        end else if (rise && state_reg == SFCF_CMD &&
                     bit_cnt_reg == 3'h7) begin
            cmd_o   <= shift_next;
            cls_reg <= sfcf_classify(shift_next);
            if (sfcf_classify(shift_next) == SFCF_CLS_BAD ||
                (busy_i && sfcf_is_array(shift_next))) begin
                state_reg <= SFCF_STANDBY;
            end else begin
                state_reg <= SFCF_ACTIVE;
            end
        end
    end

    // Active flag for the core
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            active_o <= 1'b0;
        end else begin
            active_o <= (state_reg == SFCF_ACTIVE) && !cs_rise;
        end
    end

    // Address capture after the command byte
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            addr_o <= '0;
        end else if (rise && state_reg == SFCF_ACTIVE &&
                     byte_cnt_reg < 2'(ADDR_BYTES)) begin
            addr_o <= {addr_o[ADDR_W-2:0], si_s};
        end
    end

    // End of frame: execute or reject modifying commands
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            exec_o   <= 1'b0;
            reject_o <= 1'b0;
        end else begin
            exec_o   <= 1'b0;
            reject_o <= 1'b0;
            if (cs_rise && state_reg == SFCF_ACTIVE &&
                cls_reg == SFCF_CLS_MOD) begin
                if (bit_cnt_reg == 3'h0) begin
                    exec_o <= 1'b1;
                end else begin
                    reject_o <= 1'b1;
                end
            end
        end
    end

    logic [7:0] out_sh_reg;
    logic       out_on_reg;
    // Output shifter, updated on falling serial edges
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            out_sh_reg <= RESP_RESET;
            out_on_reg <= 1'b0;
            load_o     <= 1'b0;
            so_o       <= 1'b0;
        end else begin
            load_o <= 1'b0;
            if (cs_rise || state_reg != SFCF_ACTIVE ||
                cls_reg != SFCF_CLS_READ) begin
                out_on_reg <= 1'b0;
            end else if (fall) begin
                out_on_reg <= 1'b1;
                if (bit_cnt_reg == 3'h0) begin
                    so_o       <= resp_data_i[7];
                    out_sh_reg <= {resp_data_i[6:0], 1'b0};
                    load_o     <= 1'b1;
                end else begin
                    so_o       <= out_sh_reg[7];
                    out_sh_reg <= {out_sh_reg[6:0], 1'b0};
                end
            end
        end
    end

    // Output enable, low while driving
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            so_oe_n_o <= 1'b1;
        end else begin
            so_oe_n_o <= !(out_on_reg && state_reg == SFCF_ACTIVE &&
                           !cs_rise);
        end
    end

    // Framing checks on the system clock
    standby_quiet_a: assert property (
        $past(state_reg) == SFCF_STANDBY |-> so_oe_n_o)
        else $error("Output driven in standby");
    bad_cmd_a: assert property (
        (rise && state_reg == SFCF_CMD && bit_cnt_reg == 3'h7 && !cs_fall &&
         !cs_rise && sfcf_classify(shift_next) == SFCF_CLS_BAD)
        |=> state_reg == SFCF_STANDBY)
        else $error("Bad command not sent to standby");
    good_cmd_a: assert property (
        (rise && state_reg == SFCF_CMD && bit_cnt_reg == 3'h7 && !cs_fall &&
         !cs_rise && sfcf_classify(shift_next) != SFCF_CLS_BAD &&
         !(busy_i && sfcf_is_array(shift_next)))
        |=> state_reg == SFCF_ACTIVE)
        else $error("Valid command not made active");
    standby_hold_a: assert property (
        (state_reg == SFCF_STANDBY && !cs_fall && !cs_rise)
        |=> state_reg == SFCF_STANDBY)
        else $error("Standby left early");
    active_end_a: assert property (
        cs_rise |=> state_reg == SFCF_IDLE ##1 !active_o)
        else $error("Active past select rise");
    active_flag_a: assert property (
        active_o |-> $past(state_reg) == SFCF_ACTIVE)
        else $error("Active flag without active state");
    reject_odd_a: assert property (
        reject_o |-> $past(bit_cnt_reg) != 3'h0 && !exec_o)
        else $error("Reject at byte boundary");
    exec_even_a: assert property (
        exec_o |-> $past(bit_cnt_reg) == 3'h0 &&
                   $past(cls_reg) == SFCF_CLS_MOD)
        else $error("Execute off boundary");
    busy_block_a: assert property (
        (rise && state_reg == SFCF_CMD && bit_cnt_reg == 3'h7 && busy_i &&
         !cs_fall && !cs_rise && sfcf_is_array(shift_next))
        |=> state_reg != SFCF_ACTIVE)
        else $error("Array access while busy");
    shift_on_rise_a: assert property (
        $changed(shift_reg) |-> $past(rise))
        else $error("Input shifted off rising edge");
    cmd_capture_a: assert property (
        (rise && state_reg == SFCF_CMD && bit_cnt_reg == 3'h7 && !cs_fall &&
         !cs_rise) |=> cmd_o == $past(shift_next))
        else $error("Command byte not captured");
    so_on_fall_a: assert property (
        $changed(so_o) |-> $past(fall))
        else $error("Output changed off falling edge");
    read_stop_a: assert property (
        cs_rise |=> ##1 so_oe_n_o)
        else $error("Output driven after select rise");
    load_read_a: assert property (
        load_o |-> $past(cls_reg) == SFCF_CLS_READ)
        else $error("Data out for non-read command");
    drive_read_a: assert property (
        !so_oe_n_o |-> $past(state_reg) == SFCF_ACTIVE &&
                       $past(cls_reg) == SFCF_CLS_READ)
        else $error("Output driven outside a read");

    // Main scenarios reached
    cmd_seen_c: cover property (
        state_reg == SFCF_CMD ##[1:200] state_reg == SFCF_ACTIVE);
    standby_c: cover property (state_reg == SFCF_STANDBY);
    exec_c: cover property (exec_o);
    reject_c: cover property (reject_o);
    read_out_c: cover property (load_o ##[1:20] !so_oe_n_o);
endmodule

// ===== sfcf_pkg.sv
// Shared constants for the serial flash command framing block
package sfcf_pkg;
    localparam int          CMD_W         = 8;
    localparam int          ADDR_W        = 24;
    localparam int          ADDR_BYTES    = 3;
    localparam logic [7:0]  RESP_RESET    = 8'h00;
    // Command codes used by the decoder
    localparam logic [7:0]  write_enable_cmd           = 8'h06;
    localparam logic [7:0]  write_disable_cmd          = 8'h04;
    localparam logic [7:0]  read_identification_cmd    = 8'h9f;
    localparam logic [7:0]  read_status_cmd            = 8'h05;
    localparam logic [7:0]  block_write_lock_cmd       = 8'he2;
    localparam logic [7:0]  read_block_lock_status_cmd = 8'hfb;
    localparam logic [7:0]  CMD_UNPROT_C               = 8'hf3;
    localparam logic [7:0]  CMD_READ_C                 = 8'h03;
    localparam logic [7:0]  CMD_FREAD_C                = 8'h0b;
    localparam logic [7:0]  dual_output_array_read_cmd = 8'h3b;
    localparam logic [7:0]  quad_output_array_read_cmd = 8'h6b;
    localparam logic [7:0]  dual_io_array_read_cmd     = 8'hbb;
    localparam logic [7:0]  quad_io_array_read_cmd     = 8'heb;
    localparam logic [7:0]  quad_page_program_cmd      = 8'h38;
    localparam logic [7:0]  sector_erase_cmd           = 8'h20;
    localparam logic [7:0]  page_program_cmd           = 8'h02;
    // Command classes
    typedef enum logic [1:0] {
        SFCF_CLS_BAD,
        SFCF_CLS_READ,
        SFCF_CLS_MOD
    } sfcf_cls_e;
endpackage

// ===== sfcf_host_model.sv
// Host controller model driving the serial link of the flash front end
module sfcf_host_model (
    input  wire logic clock_i,
    input  wire logic so_i,
    input  wire logic so_oe_n_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      si_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic so_line;
    // A released output line shows the inverse of its last bit
    assign so_line = so_oe_n_i ? ~so_i : so_i;

    // Link parked: select high, clock low
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end

    // Let a number of system clock falling edges pass
    task automatic idle(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    // One framed transfer, MSB first; idle clock level picks mode 0 or 3
    task automatic frame(input logic [31:0] bits, input int n,
                         input logic cpol, output logic [7:0] rd);
        rd = 8'h00;
        @(negedge clock_i);
        sclk_o = cpol;
        idle(4);
        cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            idle(8);
            sclk_o = 1'b0;
            si_o   = bits[31-i];
            idle(8);
            sclk_o = 1'b1;
            rd     = {rd[6:0], so_line};
        end
        idle(8);
        sclk_o = cpol;
        idle(4);
        cs_n_o = 1'b1;
        si_o   = ~si_o;                // Released line shows no stale bit
        idle(8);
    endtask
endmodule

// ===== tb_top.sv
// Self-checking testbench for the serial flash command framing block
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import sfcf_pkg::*;

    logic              clock_i     = 1'b0;
    logic              sys_rst_i   = 1'b1;
    logic              busy_i      = 1'b0;
    logic [7:0]        resp_data_i = 8'ha5;
    logic              sclk, cs_n, si, so, so_oe_n;
    logic              active, exec, reject, load;
    logic [7:0]        cmd, rd;
    logic [ADDR_W-1:0] addr;
    logic              saw_active, saw_drive;
    int                fail_count  = 0;
    int                comparisons = 0;
    int                exec_cnt, rej_cnt, load_cnt;

    // System clock, 100 MHz
    always #5 clock_i = ~clock_i;

    sfcf_top sfcf_top_inst (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk),
        .cs_n_i(cs_n), .si_i(si), .busy_i(busy_i),
        .resp_data_i(resp_data_i), .so_o(so), .so_oe_n_o(so_oe_n),
        .active_o(active), .cmd_o(cmd), .addr_o(addr), .exec_o(exec),
        .reject_o(reject), .load_o(load)
    );

    sfcf_host_model sfcf_host_model_inst (
        .clock_i(clock_i), .so_i(so), .so_oe_n_i(so_oe_n),
        .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si)
    );

    // Strobe counters and frame observers, sampled mid-cycle
    always @(negedge clock_i) begin
        if (exec === 1'b1) exec_cnt++;
        if (reject === 1'b1) rej_cnt++;
        if (load === 1'b1) load_cnt++;
        if (active === 1'b1) saw_active = 1'b1;
        if (so_oe_n === 1'b0) saw_drive = 1'b1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (fail_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic clear();
        exec_cnt   = 0;
        rej_cnt    = 0;
        load_cnt   = 0;
        saw_active = 1'b0;
        saw_drive  = 1'b0;
    endtask

    // Write enable in mode 0, ended on a byte boundary
    task automatic s_write_enable_cmd();
        clear();
        sfcf_host_model_inst.frame({write_enable_cmd, 24'h0}, 8, 1'b0, rd);
        check(exec_cnt, 1);
        check(rej_cnt, 0);
        check(cmd, write_enable_cmd);
        check(saw_active, 1'b1);
        check(active, 1'b0);
    endtask

    // Write disable cut three bits into the next byte
    task automatic s_reject();
        clear();
        sfcf_host_model_inst.frame({write_disable_cmd, 24'h0}, 11, 1'b0, rd);
        check(rej_cnt, 1);
        check(exec_cnt, 0);
    endtask

    // Status read in mode 3, whole byte then a cut-short byte
    task automatic s_read();
        clear();
        sfcf_host_model_inst.frame({read_status_cmd, 24'h0}, 16, 1'b1, rd);
        check(rd, 8'ha5);
        check(load_cnt != 0, 1'b1);
        check(so_oe_n, 1'b1);
        clear();
        sfcf_host_model_inst.frame({read_status_cmd, 24'h0}, 12, 1'b1, rd);
        check(rd[3:0], 4'ha);
        check(rej_cnt, 0);
        check(so_oe_n, 1'b1);
    endtask

    // Unknown code followed by a valid one in the same frame
    task automatic s_bad();
        clear();
        sfcf_host_model_inst.frame({8'h77, write_enable_cmd, 16'h0}, 16,
                                   1'b0, rd);
        check(saw_active, 1'b0);
        check(exec_cnt + rej_cnt, 0);
        check(saw_drive, 1'b0);
    endtask

    // Array read refused while busy, then taken with its address
    task automatic s_busy();
        clear();
        busy_i = 1'b1;
        sfcf_host_model_inst.frame({CMD_READ_C, 24'h123456}, 32, 1'b0, rd);
        check(saw_active, 1'b0);
        check(saw_drive, 1'b0);
        clear();
        sfcf_host_model_inst.frame({read_status_cmd, 24'h0}, 16, 1'b0, rd);
        check(saw_active, 1'b1);
        check(rd, 8'ha5);
        busy_i = 1'b0;                 // Poll done, core ready
        clear();
        sfcf_host_model_inst.frame({CMD_READ_C, 24'h123456}, 32, 1'b0, rd);
        check(saw_active, 1'b1);
        check(addr, 24'h123456);
    endtask

    // Reset in mid-run returns every output to its idle value
    task automatic s_reset();
        @(negedge clock_i);
        sys_rst_i = 1'b1;
        repeat (3) @(negedge clock_i);
        check(cmd, 8'h00);
        check(addr, 24'h0);
        check(active, 1'b0);
        check(so_oe_n, 1'b1);
        check({exec, reject, load}, 3'h0);
        sys_rst_i = 1'b0;
        repeat (4) @(negedge clock_i);
    endtask

    // Hang guard
    initial begin
        #200us;
        fail_count++;
        stop_test();
    end

    // Main sequence
    initial begin
        clear();
        repeat (3) @(negedge clock_i);
        sys_rst_i = 1'b0;
        s_write_enable_cmd();
        s_reject();
        s_read();
        s_bad();
        s_busy();
        s_reset();
        s_write_enable_cmd();
        stop_test();
    end
endmodule
